//--- src/chg_pin_pkg.sv
// Shared constants and carrier types for the charger pin logic
package chg_pin_pkg;

    // Clock rate and interrupt pulse timing
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned FAULT_PULSE_US  = 128;
    localparam int unsigned FAULT_PULSE_CYC =
        (FAULT_PULSE_US * (CLK_HZ / 1_000_000) > 0) ?
        FAULT_PULSE_US * (CLK_HZ / 1_000_000) : 1;

    // Wishbone register byte addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_FAULT   = 8'h08;

    // Control register field positions
    localparam int unsigned CTL_STATUS_SEL_LSB = 0;
    localparam int unsigned CTL_GPO_LEVEL_BIT  = 2;
    localparam int unsigned CTL_RAIL_LSB       = 4;
    localparam int unsigned CTL_SHIP_REQ_BIT   = 8;
    localparam int unsigned CTL_RESET_REQ_BIT  = 9;

    // Reset values
    localparam logic [1:0] STATUS_SEL_RESET = 2'h0;
    localparam logic [2:0] RAIL_RESET       = 3'h0;
    localparam logic       GPO_LEVEL_RESET  = 1'b1;

    // Status output source selection
    localparam logic [1:0] STATUS_SEL_PGOOD = 2'h0;
    localparam logic [1:0] STATUS_SEL_GPO   = 2'h1;
    localparam logic [1:0] STATUS_SEL_MRCPY = 2'h2;

    // System rail setting code for input pass-through
    localparam logic [2:0] RAIL_PASS_THROUGH = 3'h7;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_LOW_POWER,
        PWR_SHIP
    } power_state_t;

    typedef struct packed {
        logic [1:0] status_sel;
        logic       gpo_level;
        logic [2:0] system_rail_setting;
    } ctrl_cfg_t;

    typedef struct packed {
        logic input_supply;
        logic charge_enable_n;
        logic low_power_select_n;
        logic manual_reset_n;
    } pin_in_t;

endpackage

//--- src/sync2.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= RESET_VAL;
            q_o  <= RESET_VAL;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // sync2

//--- src/pulse_timer.sv
// Fixed-length pulse generator, retriggerable only in the last cycle of a pulse
`timescale 1ns/1ps
module pulse_timer #(
    parameter int unsigned LENGTH = 3200
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic trig_i,
    output logic      pulse_o
);
    localparam int unsigned CW = $clog2(LENGTH + 1);
    logic [CW-1:0] remain;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            remain  <= '0;
            pulse_o <= 1'b0;
        end else if (trig_i && remain == '0) begin
            // A fault during a pulse is absorbed, except in its last cycle, where it extends the pulse by a full length
            remain  <= CW'(LENGTH - 1);
            pulse_o <= 1'b1;
        end else if (remain != '0) begin
            remain  <= remain - 1'b1;
            pulse_o <= 1'b1;
        end else begin
            pulse_o <= 1'b0;
        end
    end
endmodule // pulse_timer

//--- src/charger_control_pin_logic.sv
// Pin-level control logic of the charger: charge gate, low power, fault pulse, status pin
// Overview of operation
// - Charging enabled when charge-enable pin is low and input supply is valid.
// - On battery, low-power select driven low puts the device in low power mode.
// - Low-power select is ignored whenever the input supply is present.
// - Faults are reported on a dedicated open-drain interrupt pin.
// - Each fault gives one 128 us low pulse on the interrupt pin. Here a fault during a pulse gives none, but one in its last cycle lengthens it.
// - Manual reset pin resets the device or wakes it from ship mode.
// - Status pin shows power good, or a general output, or manual reset copy.
// - System rail setting code 111 selects input pass-through.
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module charger_control_pin_logic
    import chg_pin_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = FAULT_PULSE_CYC
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    input  wire logic        INPUT_SUPPLY_I,
    input  wire logic        CHARGE_ENABLE_N_I,
    input  wire logic        LOW_POWER_SELECT_N_I,
    input  wire logic        MANUAL_RESET_N_I,
    input  wire logic        POWER_GOOD_I,
    input  wire logic        FAULT_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             CHARGE_EN_O,
    output logic             LOW_POWER_O,
    output logic             SERIAL_ALLOWED_O,
    output logic             PASS_THROUGH_O,
    output logic             DEVICE_RESET_O,
    output logic             SHIP_MODE_O,
    output logic             INT_N_O,
    output logic             INT_OE_O,
    output logic             STATUS_N_O,
    output logic             STATUS_OE_O
);
    pin_in_t      pins;
    ctrl_cfg_t    cfg;
    power_state_t pstate;
    logic         button_prev;
    logic         fault_sticky;
    logic         fault_pulse;
    logic         wb_req;
    logic         next_status_n;
    logic [31:0]  next_rdata;

    // Charge-enable and select pins float low, so reset to the enabled level
    sync2 #(
        .WIDTH    (4),
        .RESET_VAL(4'h1)
    ) u_pin_sync (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .d_i  ({INPUT_SUPPLY_I, CHARGE_ENABLE_N_I, LOW_POWER_SELECT_N_I, MANUAL_RESET_N_I}),
        .q_o  (pins)
    );

    pulse_timer #(
        .LENGTH(PULSE_CYCLES)
    ) u_fault_pulse (
        .clk_i  (CLK_SYS_I),
        .rst_i  (RST_I),
        .trig_i (FAULT_I),
        .pulse_o(fault_pulse)
    );

    assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

    // Bus acknowledge: one cycle after the request, dropped the next cycle
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= wb_req;
        end
    end

    // Configuration register writes, byte lane 0 only
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            cfg.status_sel          <= STATUS_SEL_RESET;
            cfg.gpo_level           <= GPO_LEVEL_RESET;
            cfg.system_rail_setting <= RAIL_RESET;
        end else if (wb_req && WB_WE_I && WB_ADR_I == ADDR_CONTROL) begin
            if (WB_SEL_I[0]) begin
                cfg.status_sel          <= WB_DAT_I[CTL_STATUS_SEL_LSB +: 2];
                cfg.gpo_level           <= WB_DAT_I[CTL_GPO_LEVEL_BIT];
                cfg.system_rail_setting <= WB_DAT_I[CTL_RAIL_LSB +: 3];
            end
        end
    end

    // Power state: low power and ship handling
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            pstate         <= PWR_ACTIVE;
            button_prev    <= 1'b1;
            DEVICE_RESET_O <= 1'b0;
        end else begin
            button_prev    <= pins.manual_reset_n;
            DEVICE_RESET_O <= 1'b0;
            case (pstate)
                PWR_ACTIVE, PWR_LOW_POWER: begin
                    if (wb_req && WB_WE_I && WB_ADR_I == ADDR_CONTROL && WB_SEL_I[1]
                        && WB_DAT_I[CTL_SHIP_REQ_BIT]) begin
                        pstate <= PWR_SHIP;
                    end else if (!pins.input_supply && !pins.low_power_select_n) begin
                        pstate <= PWR_LOW_POWER;
                    end else begin
                        pstate <= PWR_ACTIVE;
                    end
                    // Falling edge of manual reset outside ship mode resets
                    if ((button_prev && !pins.manual_reset_n) ||
                        (wb_req && WB_WE_I && WB_ADR_I == ADDR_CONTROL && WB_SEL_I[1]
                         && WB_DAT_I[CTL_RESET_REQ_BIT])) begin
                        DEVICE_RESET_O <= 1'b1;
                    end
                end
                PWR_SHIP: begin
                    if (button_prev && !pins.manual_reset_n) begin
                        pstate <= PWR_ACTIVE;
                    end
                end
                default: pstate <= PWR_ACTIVE;
            endcase
        end
    end

    // Sticky fault record, set wins over a clearing write
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            fault_sticky <= 1'b0;
        end else if (FAULT_I) begin
            fault_sticky <= 1'b1;
        end else if (wb_req && WB_WE_I && WB_ADR_I == ADDR_FAULT && WB_SEL_I[0]
                     && WB_DAT_I[0]) begin
            fault_sticky <= 1'b0;
        end
    end

    // Derived pin outputs
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            CHARGE_EN_O      <= 1'b0;
            LOW_POWER_O      <= 1'b0;
            SERIAL_ALLOWED_O <= 1'b0;
            PASS_THROUGH_O   <= 1'b0;
            SHIP_MODE_O      <= 1'b0;
            INT_N_O          <= 1'b0;
            INT_OE_O         <= 1'b0;
            STATUS_N_O       <= 1'b0;
            STATUS_OE_O      <= 1'b0;
        end else begin
            CHARGE_EN_O      <= pins.input_supply && !pins.charge_enable_n;
            LOW_POWER_O      <= (pstate == PWR_LOW_POWER);
            // On battery the serial bus is served only with the select held high
            SERIAL_ALLOWED_O <= pins.input_supply || pins.low_power_select_n;
            PASS_THROUGH_O   <= (cfg.system_rail_setting == RAIL_PASS_THROUGH);
            SHIP_MODE_O      <= (pstate == PWR_SHIP);
            INT_N_O          <= 1'b0;
            INT_OE_O         <= fault_pulse;
            STATUS_N_O       <= 1'b0;
            STATUS_OE_O      <= !next_status_n;
        end
    end

    always_comb begin
        case (cfg.status_sel)
            STATUS_SEL_PGOOD: next_status_n = !POWER_GOOD_I;
            STATUS_SEL_GPO:   next_status_n = cfg.gpo_level;
            STATUS_SEL_MRCPY: next_status_n = pins.manual_reset_n;
            default:          next_status_n = 1'b1;
        endcase
    end

    always_comb begin
        next_rdata = '0;
        case (WB_ADR_I)
            ADDR_CONTROL: begin
                next_rdata[CTL_STATUS_SEL_LSB +: 2] = cfg.status_sel;
                next_rdata[CTL_GPO_LEVEL_BIT]       = cfg.gpo_level;
                next_rdata[CTL_RAIL_LSB +: 3]       = cfg.system_rail_setting;
            end
            ADDR_STATUS: begin
                next_rdata[0] = CHARGE_EN_O;
                next_rdata[1] = LOW_POWER_O;
                next_rdata[2] = SHIP_MODE_O;
                next_rdata[3] = pins.input_supply;
                next_rdata[4] = PASS_THROUGH_O;
                next_rdata[5] = SERIAL_ALLOWED_O;
            end
            ADDR_FAULT:   next_rdata[0] = fault_sticky;
            default:      next_rdata = '0;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            WB_DAT_O <= '0;
        end else if (wb_req && !WB_WE_I) begin
            WB_DAT_O <= next_rdata;
        end
    end

    // Interrupt driven only during a pulse, held for at least 8 cycles
    a_int_pulse_len: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        $rose(INT_OE_O) |-> INT_OE_O [*8])
        else $error("Interrupt pulse too short");
    a_int_released: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !$past(fault_pulse) |-> !INT_OE_O)
        else $error("Interrupt driven outside a pulse");
    a_int_drive_low: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        INT_OE_O |-> !INT_N_O)
        else $error("Interrupt not driven low");
    a_fault_starts_pulse: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (FAULT_I && !fault_pulse) |-> ##2 INT_OE_O)
        else $error("Fault did not start a pulse");
    a_charge_gate: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        CHARGE_EN_O |-> $past(pins.input_supply) && !$past(pins.charge_enable_n))
        else $error("Charging without valid supply or enable");
    a_select_ignored: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (pins.input_supply && pstate != PWR_SHIP) |=> ##1 !LOW_POWER_O)
        else $error("Low power entered with supply present");
    a_low_power_entry: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (!pins.input_supply && !pins.low_power_select_n && pstate == PWR_ACTIVE
         && !wb_req) |=> ##1 LOW_POWER_O)
        else $error("Low power not entered on battery");
    a_pass_through: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (cfg.system_rail_setting == RAIL_PASS_THROUGH) |=> PASS_THROUGH_O)
        else $error("Pass-through not selected for code 111");
    a_ship_wake: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (pstate == PWR_SHIP && button_prev && !pins.manual_reset_n) |=> pstate == PWR_ACTIVE)
        else $error("Manual reset did not wake from ship mode");

    // Bus handshake: one acknowledge per taken request
    a_ack_answers: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        wb_req |=> WB_ACK_O)
        else $error("Bus request not acknowledged");
    a_ack_single: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("Acknowledge held longer than one cycle");

    // Charge gate in the enabling direction
    a_charge_on: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (pins.input_supply && !pins.charge_enable_n) |=> CHARGE_EN_O)
        else $error("Charging not enabled with supply and enable");

    // Select input only matters on battery
    a_low_power_exit: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (pins.input_supply && pstate == PWR_LOW_POWER && !wb_req) |=> pstate == PWR_ACTIVE)
        else $error("Low power kept with supply present");
    a_serial_on_supply: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        pins.input_supply |=> SERIAL_ALLOWED_O)
        else $error("Serial access blocked with supply present");
    a_serial_block: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (!pins.input_supply && !pins.low_power_select_n) |=> !SERIAL_ALLOWED_O)
        else $error("Serial access allowed with select low on battery");

    // Manual reset edge: reset pulse when awake, none while shipped
    a_button_reset: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (pstate != PWR_SHIP && button_prev && !pins.manual_reset_n) |=> DEVICE_RESET_O)
        else $error("Manual reset edge gave no reset pulse");
    a_no_reset_ship: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (pstate == PWR_SHIP) |=> !DEVICE_RESET_O)
        else $error("Reset pulse while in ship mode");
    a_ship_report: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (pstate == PWR_SHIP) |=> SHIP_MODE_O)
        else $error("Ship mode not reported");

    // Status pin follows the selected source, released on select 3
    a_status_pgood: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (cfg.status_sel == STATUS_SEL_PGOOD) |=> (STATUS_OE_O == $past(POWER_GOOD_I)))
        else $error("Status pin does not follow power good");
    a_status_gpo: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (cfg.status_sel == STATUS_SEL_GPO) |=> (STATUS_OE_O == !$past(cfg.gpo_level)))
        else $error("Status pin does not follow general output level");
    a_status_copy: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (cfg.status_sel == STATUS_SEL_MRCPY) |=> (STATUS_OE_O == !$past(pins.manual_reset_n)))
        else $error("Status pin does not copy manual reset");
    a_status_released: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (cfg.status_sel == 2'h3) |=> !STATUS_OE_O)
        else $error("Status pin driven while released");
    a_status_low: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        STATUS_OE_O |-> !STATUS_N_O)
        else $error("Status pin not driven low");

    // Sticky fault record: a fault always wins over a clear
    a_fault_sticky: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FAULT_I |=> fault_sticky)
        else $error("Fault not recorded");

    // Pass-through only for its own code
    a_pass_off: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (cfg.system_rail_setting != RAIL_PASS_THROUGH) |=> !PASS_THROUGH_O)
        else $error("Pass-through selected for another code");
endmodule // charger_control_pin_logic

//--- verif/host_pin_model.sv
// Host-side model: drives the control pins and watches the interrupt wire
`timescale 1ns/1ps
module host_pin_model (
    input  wire logic        clk_i,
    input  wire logic        int_n_i,
    input  wire logic        int_oe_i,
    output logic             charge_enable_n_o,
    output logic             low_power_select_n_o,
    output logic             manual_reset_n_o,
    output logic             int_wire_o,
    output logic      [15:0] last_len_o,
    output logic      [7:0]  pulses_o
);
    logic [15:0] run = 16'h0000;

    initial begin
        charge_enable_n_o = 1'b0;
        low_power_select_n_o = 1'b1;
        manual_reset_n_o = 1'b1;
        last_len_o = 16'h0000;
        pulses_o = 8'h00;
    end

    // External pull-up holds the wire high whenever nobody pulls it down
    assign int_wire_o = int_oe_i ? int_n_i : 1'b1;

    // Measure each low pulse on the wire
    always @(posedge clk_i) begin
        if (!int_wire_o) begin
            run <= run + 16'h0001;
        end else if (run != 16'h0000) begin
            last_len_o <= run;
            pulses_o <= pulses_o + 8'h01;
            run <= 16'h0000;
        end
    end

    // Pins change just after an edge; select stays high around bus use on battery
    task automatic pins(input logic ce_n, input logic sel_n, input logic button_n);
        @(posedge clk_i);
        charge_enable_n_o <= ce_n;
        low_power_select_n_o <= sel_n;
        manual_reset_n_o <= button_n;
    endtask
endmodule // host_pin_model

//--- verif/tb_top.sv
// Self-checking bench for the charger pin logic
`timescale 1ns/1ps
module tb_top
    import chg_pin_pkg::*;
;
    localparam int unsigned PULSE = 10;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sup = 1'b0;
    logic        pgood = 1'b0;
    logic        flt = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack, chg, lpo, ser, pt, drst, ship, intn, intoe, stn, stoe;
    logic        ce_n, sel_n, button_n, int_wire;
    logic [15:0] last_len;
    logic [7:0]  pulses;
    logic [7:0]  p0;
    logic [31:0] q;
    logic        hit;
    int          fails = 0;
    int          checks_done = 0;
    int          resets = 0;
    int          rst_base;

    charger_control_pin_logic #(.PULSE_CYCLES(PULSE)) i_dut (
        .CLK_SYS_I(clk), .RST_I(rst), .INPUT_SUPPLY_I(sup), .CHARGE_ENABLE_N_I(ce_n),
        .LOW_POWER_SELECT_N_I(sel_n), .MANUAL_RESET_N_I(button_n), .POWER_GOOD_I(pgood),
        .FAULT_I(flt), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .CHARGE_EN_O(chg), .LOW_POWER_O(lpo), .SERIAL_ALLOWED_O(ser),
        .PASS_THROUGH_O(pt), .DEVICE_RESET_O(drst), .SHIP_MODE_O(ship),
        .INT_N_O(intn), .INT_OE_O(intoe), .STATUS_N_O(stn), .STATUS_OE_O(stoe));

    host_pin_model i_host (
        .clk_i(clk), .int_n_i(intn), .int_oe_i(intoe), .charge_enable_n_o(ce_n),
        .low_power_select_n_o(sel_n), .manual_reset_n_o(button_n), .int_wire_o(int_wire),
        .last_len_o(last_len), .pulses_o(pulses));

    initial begin
        forever #20 clk = ~clk;
    end

    // Counts reset pulses, some of which end before a task can look
    always @(posedge clk) begin
        if (drst === 1'b1) begin
            resets <= resets + 1;
        end
    end

    task automatic finish_test();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        cmp32({31'h0, got}, {31'h0, exp});
    endtask

    // Classic cycle: hold everything until ack is sampled high, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            finish_test();
        end
        r = rdat;
        @(posedge clk);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    // Pin-derived outputs need up to four edges after an input settles (low power takes four)
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic watch_reset(output logic seen);
        seen = 1'b0;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (drst === 1'b1) seen = 1'b1;
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, ADDR_CONTROL, 32'h0000_0000, q);
        cmp32(q, {25'h0, RAIL_RESET, 1'b0, GPO_LEVEL_RESET, STATUS_SEL_RESET});
        wb(1'b0, 8'h0C, 32'h0000_0000, q);
        cmp32(q, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            i_host.pins(i[1], i[0], 1'b1);
            sup <= i[2];
            settle();
            cmp1(chg, i[2] & ~i[1]);
            cmp1(lpo, ~i[2] & ~i[0]);
            cmp1(ser, i[2] | i[0]);
        end
        // On battery with select held high so the bus stays usable
        sup <= 1'b0;
        for (int r = 0; r < 8; r++) begin
            wb(1'b1, ADDR_CONTROL, {25'h0, r[2:0], 4'h4}, q);
            settle();
            cmp1(pt, r[2:0] === RAIL_PASS_THROUGH);
            wb(1'b0, ADDR_CONTROL, 32'h0000_0000, q);
            cmp32(q, {25'h0, r[2:0], 4'h4});
        end
        // Source table: power good, general output, manual reset copy, released
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, ADDR_CONTROL, {28'h0, 1'b0, ~k[0], k[2:1]}, q);
            pgood <= k[0];
            i_host.pins(1'b0, 1'b1, ~(k[0] & (k[2:1] == STATUS_SEL_MRCPY)));
            settle();
            cmp1(stoe, (k[2:1] != 2'h3) & k[0]);
            cmp1(stn, 1'b0);
        end
        sup <= 1'b1;
        i_host.pins(1'b0, 1'b1, 1'b1);
        settle();
        i_host.pins(1'b0, 1'b1, 1'b0);
        watch_reset(hit);
        cmp1(hit, 1'b1);
        i_host.pins(1'b0, 1'b1, 1'b1);
        wb(1'b1, ADDR_CONTROL, 32'h0000_0104, q);
        settle();
        cmp1(ship, 1'b1);
        i_host.pins(1'b0, 1'b1, 1'b0);
        watch_reset(hit);
        cmp1(hit, 1'b0);
        cmp1(ship, 1'b0);
        // Awake on supply, charging, no pass-through, bus usable
        wb(1'b0, ADDR_STATUS, 32'h0000_0000, q);
        cmp32(q, 32'h0000_0029);
        rst_base = resets;
        wb(1'b1, ADDR_CONTROL, 32'h0000_0204, q);
        settle();
        cmp32(resets, rst_base + 1);
        // Second fault lands inside the pulse and must be absorbed
        p0 = pulses;
        cmp1(int_wire, 1'b1);
        @(posedge clk); flt <= 1'b1;
        @(posedge clk); flt <= 1'b0;
        repeat (3) @(posedge clk);
        flt <= 1'b1;
        @(posedge clk); flt <= 1'b0;
        for (int n = 0; n < 40 && pulses === p0; n++) @(posedge clk);
        repeat (20) @(posedge clk);
        #1;
        cmp32({24'h0, pulses}, {24'h0, p0 + 8'h01});
        cmp32({16'h0, last_len}, PULSE);
        cmp1(intn, 1'b0);
        cmp1(int_wire, 1'b1);
        wb(1'b0, ADDR_FAULT, 32'h0000_0000, q);
        cmp32(q, 32'h0000_0001);
        wb(1'b1, ADDR_FAULT, 32'h0000_0001, q);
        wb(1'b0, ADDR_FAULT, 32'h0000_0000, q);
        cmp32(q, 32'h0000_0000);
        finish_test();
    end
endmodule // tb_top
